/* File: include/lss_pkg.sv */
`default_nettype none
package lss_pkg;
	// ****************************************************
	// list geometry and bus
	// ****************************************************
	localparam int          NUM_POINTS  = 10;
	localparam int          IDX_W       = 4;
	localparam logic [3:0]  NO_POINT    = 4'h_f;
	localparam int          ADDR_W      = 12;

	// ****************************************************
	// register byte offsets
	// ****************************************************
	localparam logic [11:0] OFS_CTRL    = 12'h_000;
	localparam logic [11:0] OFS_STATUS  = 12'h_004;
	localparam logic [11:0] OFS_MASK    = 12'h_008;
	localparam logic [11:0] OFS_STATE   = 12'h_00c;
	localparam logic [11:0] OFS_RESULT  = 12'h_010;
	localparam logic [11:0] OFS_TABLE   = 12'h_040;
	localparam logic [11:0] OFS_TBL_END = 12'h_0e0;
	// word within one 16-byte point slot
	localparam logic [1:0]  SLOT_VALUE  = 2'h_0;
	localparam logic [1:0]  SLOT_CFG    = 2'h_1;
	localparam logic [1:0]  SLOT_LOWER  = 2'h_2;
	localparam logic [1:0]  SLOT_UPPER  = 2'h_3;

	// ****************************************************
	// control fields
	// ****************************************************
	localparam int          CTRL_RUN_PAGE = 0;
	localparam int          CTRL_WHOLE    = 1;
	localparam int          CTRL_SRC_LO   = 2;
	localparam int          CTRL_PARAM_LO = 4;
	localparam int          CTRL_SOFT_BUS = 8;
	localparam logic [31:0] CTRL_RESET    = 32'h_0000_0006;

	// ****************************************************
	// point config fields
	// ****************************************************
	localparam int          CFG_ENABLE  = 0;
	localparam int          CFG_LMT_LO  = 1;

	// ****************************************************
	// status bits and state word
	// ****************************************************
	localparam int          ST_POINT_DONE = 0;
	localparam int          ST_LIST_DONE  = 1;
	localparam int          ST_POINT_FAIL = 2;
	localparam int          ST_W          = 3;
	localparam int          STATE_BUSY    = 4;

	// ****************************************************
	// encodings
	// ****************************************************
	typedef enum logic [1:0] {
		TRIG_INTERNAL, key_trigger_source,
		handler_line_trigger_source, TRIG_SERIAL
	} lss_trig_src_t;
	typedef enum logic [1:0] {
		sweep_by_frequency, sweep_by_voltage, sweep_by_current,
		SWEEP_RSVD
	} lss_sweep_t;
	localparam logic [1:0]  LMT_OFF       = 2'h_0;
	localparam logic [1:0]  LMT_PRIMARY   = 2'h_1;
	localparam logic [1:0]  limit_on_secondary_result = 2'h_2;
	localparam logic [1:0]  VERDICT_NONE  = 2'h_0;
	localparam logic [1:0]  VERDICT_PASS  = 2'h_1;
	localparam logic [1:0]  VERDICT_FAIL  = 2'h_2;
endpackage
`default_nettype wire

/* File: rtl/lss_trig_edge.sv */
`timescale 1ns/10ps
`default_nettype none
module lss_trig_edge
(
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic [2:0] level_in,
	output logic      [2:0] rise_pulse
);
	logic [2:0] prev;

	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_edge
			always_ff @(posedge sys_clk)
			begin
				if (!nrst)
					prev[g] <= 1'b0;
				else
					prev[g] <= level_in[g];
			end
			assign rise_pulse[g] = level_in[g] & ~prev[g];
		end
	endgenerate
endmodule // lss_trig_edge
`default_nettype wire

/* File: rtl/lss_limit_cmp.sv */
`timescale 1ns/10ps
`default_nettype none
module lss_limit_cmp
(
	input  wire logic [1:0]  limit_parameter_select,
	input  wire logic [31:0] primary,
	input  wire logic [31:0] secondary,
	input  wire logic [31:0] lower,
	input  wire logic [31:0] upper,
	output logic      [1:0]  verdict
);
	logic [31:0] picked;

	// inclusive window on the selected result
	always_comb
	begin
		picked = (limit_parameter_select ==
			lss_pkg::limit_on_secondary_result) ? secondary : primary;
		if (limit_parameter_select == lss_pkg::LMT_OFF ||
			limit_parameter_select == 2'h_3)
			verdict = lss_pkg::VERDICT_NONE;
		else if (picked >= lower && picked <= upper)
			verdict = lss_pkg::VERDICT_PASS;
		else
			verdict = lss_pkg::VERDICT_FAIL;
	end
endmodule // lss_limit_cmp
`default_nettype wire

/* File: rtl/lss_list_sweep_sequencer.sv */
// Operation
// - table holds up to ten sweep points, run in table order
// - whole-list mode with key source runs all points, then waits
// - step mode with key source runs first point, then one per trigger
// - trigger source picks internal, key, handler line or serial bus
// - internal source sweeps the list continuously without any trigger
// - each handler line pulse counts as one trigger
// - each serial trigger command counts as one trigger
// - serial triggers sweep points like the other triggered sources
// - first entry to list page selects key source and runs once
// - global selector applies point values as frequency, voltage or current
// - each point has an enable; disabled points are skipped
// - each point selects primary, secondary or no limit check
// - each point stores a lower limit
// - each point stores an upper limit
// - each measured point is compared and its verdict reported
// - index of the point under measurement is exposed
`timescale 1ns/10ps
`default_nettype none
module lss_list_sweep_sequencer
(
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        key_trig,
	input  wire logic        handler_trig,
	input  wire logic        bus_trig_cmd,
	output logic             meas_start,
	output logic      [31:0] meas_value,
	output logic      [1:0]  sweep_param,
	input  wire logic        meas_done,
	input  wire logic [31:0] meas_primary,
	input  wire logic [31:0] meas_secondary,
	output logic      [3:0]  active_point,
	output logic             sweep_busy,
	output logic             irq
);
	// ****************************************************
	// declarations
	// ****************************************************
	typedef enum logic [1:0] {S_IDLE, S_START, S_WAIT} lss_state_t;

	lss_state_t  state;
	logic [31:0] ctrl;
	logic [31:0] pt_value [lss_pkg::NUM_POINTS];
	logic [2:0]  pt_cfg   [lss_pkg::NUM_POINTS];
	logic [31:0] pt_lower [lss_pkg::NUM_POINTS];
	logic [31:0] pt_upper [lss_pkg::NUM_POINTS];
	logic [19:0] result;
	logic [2:0]  status;
	logic [2:0]  mask;
	logic [3:0]  step_ptr;
	logic        entered_once;
	logic        run_page_q;
	logic        auto_run;
	logic        whole_run;
	logic [2:0]  edges;
	logic        setup_ph;
	logic        access_wr;
	logic        access_rd;
	logic        addr_ok;
	logic [9:0]  en_vec;
	logic        soft_bus;
	logic        any_trig;
	logic [3:0]  trig_target;
	logic [3:0]  seq_next;
	logic [1:0]  verdict;
	logic [2:0]  events;
	logic [1:0]  src;

	// ****************************************************
	// decode helpers
	// ****************************************************
	// point slot index of a table address, no_point outside the table
	function automatic logic [3:0] slot_of(input logic [11:0] a);
		logic [11:0] rel;
		rel = a - lss_pkg::OFS_TABLE;
		if (a < lss_pkg::OFS_TABLE || a >= lss_pkg::OFS_TBL_END)
			return lss_pkg::NO_POINT;
		return rel[7:4];
	endfunction

	// first enabled point at or after start
	function automatic logic [3:0] first_en(input logic [9:0] en,
		input logic [3:0] start);
		logic [3:0] hit;
		hit = lss_pkg::NO_POINT;
		for (int i = lss_pkg::NUM_POINTS - 1; i >= 0; i--)
		begin
			if (en[i] && 4'(i) >= start)
				hit = 4'(i);
		end
		return hit;
	endfunction

	// ****************************************************
	// apb slave
	// ****************************************************
	assign setup_ph  = psel & ~penable;
	assign access_wr = psel & penable & pwrite & addr_ok;
	assign access_rd = psel & penable & ~pwrite & addr_ok;
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & ~addr_ok;

	always_comb
	begin
		addr_ok = (paddr[1:0] == 2'h_0) &&
			(paddr == lss_pkg::OFS_CTRL || paddr == lss_pkg::OFS_STATUS ||
			paddr == lss_pkg::OFS_MASK || paddr == lss_pkg::OFS_STATE ||
			paddr == lss_pkg::OFS_RESULT ||
			slot_of(paddr) != lss_pkg::NO_POINT);
	end

	// read data is latched in the setup phase so it comes from a flop
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			prdata <= 32'h_0000_0000;
		else if (setup_ph && !pwrite)
		begin
			prdata <= 32'h_0000_0000;
			if (paddr == lss_pkg::OFS_CTRL)
				prdata <= ctrl;
			else if (paddr == lss_pkg::OFS_STATUS)
				prdata <= {29'h_0, status};
			else if (paddr == lss_pkg::OFS_MASK)
				prdata <= {29'h_0, mask};
			else if (paddr == lss_pkg::OFS_STATE)
				prdata <= {27'h_0, sweep_busy, active_point};
			else if (paddr == lss_pkg::OFS_RESULT)
				prdata <= {12'h_0, result};
			else if (slot_of(paddr) != lss_pkg::NO_POINT)
			begin
				case (paddr[3:2])
				lss_pkg::SLOT_VALUE: prdata <= pt_value[slot_of(paddr)];
				lss_pkg::SLOT_CFG:
					prdata <= {29'h_0, pt_cfg[slot_of(paddr)]};
				lss_pkg::SLOT_LOWER: prdata <= pt_lower[slot_of(paddr)];
				lss_pkg::SLOT_UPPER: prdata <= pt_upper[slot_of(paddr)];
				default: prdata <= 32'h_0000_0000;
				endcase
			end
		end
	end

	// ****************************************************
	// control register and first entry
	// ****************************************************
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			ctrl         <= lss_pkg::CTRL_RESET;
			entered_once <= 1'b0;
			run_page_q   <= 1'b0;
			auto_run     <= 1'b0;
		end
		else
		begin
			if (access_wr && paddr == lss_pkg::OFS_CTRL)
				ctrl <= {23'h_0, 1'b0, 2'h_0, pwdata[5:0]};
			run_page_q <= ctrl[lss_pkg::CTRL_RUN_PAGE];
			auto_run   <= 1'b0;
			// entering the run page performs one run by itself
			if (ctrl[lss_pkg::CTRL_RUN_PAGE] && !run_page_q)
			begin
				auto_run <= 1'b1;
				if (!entered_once)
				begin
					ctrl[3:2] <= 2'(lss_pkg::key_trigger_source);
					entered_once <= 1'b1;
				end
			end
		end
	end

	assign src         = ctrl[3:2];
	assign sweep_param = ctrl[5:4];
	assign soft_bus    = access_wr && paddr == lss_pkg::OFS_CTRL &&
		pwdata[lss_pkg::CTRL_SOFT_BUS];

	// ****************************************************
	// point table
	// ****************************************************
	genvar p;
	generate
		for (p = 0; p < lss_pkg::NUM_POINTS; p++)
		begin : g_pt
			always_ff @(posedge sys_clk)
			begin
				if (!nrst)
				begin
					pt_value[p] <= 32'h_0000_0000;
					pt_cfg[p]   <= 3'h_0;
					pt_lower[p] <= 32'h_0000_0000;
					pt_upper[p] <= 32'h_0000_0000;
				end
				else if (access_wr && slot_of(paddr) == 4'(p))
				begin
					case (paddr[3:2])
					lss_pkg::SLOT_VALUE: pt_value[p] <= pwdata;
					lss_pkg::SLOT_CFG:   pt_cfg[p]   <= pwdata[2:0];
					lss_pkg::SLOT_LOWER: pt_lower[p] <= pwdata;
					lss_pkg::SLOT_UPPER: pt_upper[p] <= pwdata;
					default: pt_value[p] <= pt_value[p];
					endcase
				end
			end
			assign en_vec[p] = pt_cfg[p][lss_pkg::CFG_ENABLE];
		end
	endgenerate

	// ****************************************************
	// trigger selection
	// ****************************************************
	lss_trig_edge u_edge
	(
		.sys_clk    (sys_clk),
		.nrst       (nrst),
		.level_in   ({bus_trig_cmd, handler_trig, key_trig}),
		.rise_pulse (edges)
	);

	always_comb
	begin
		case (src)
		2'(lss_pkg::TRIG_INTERNAL): any_trig = 1'b1;
		2'(lss_pkg::key_trigger_source): any_trig = edges[0];
		2'(lss_pkg::handler_line_trigger_source):
			any_trig = edges[1];
		2'(lss_pkg::TRIG_SERIAL):
			any_trig = edges[2] | soft_bus;
		default: any_trig = 1'b0;
		endcase
		any_trig = (any_trig & ctrl[lss_pkg::CTRL_RUN_PAGE]) | auto_run;
	end

	// whole list starts at the top, a step continues from its pointer
	always_comb
	begin
		if (ctrl[lss_pkg::CTRL_WHOLE])
			trig_target = first_en(en_vec, 4'h_0);
		else
		begin
			trig_target = first_en(en_vec, step_ptr);
			if (trig_target == lss_pkg::NO_POINT)
				trig_target = first_en(en_vec, 4'h_0);
		end
		seq_next = first_en(en_vec, active_point + 4'h_1);
	end

	// ****************************************************
	// sequencer
	// ****************************************************
	lss_limit_cmp u_cmp
	(
		.limit_parameter_select (pt_cfg[active_point][2:1]),
		.primary                (meas_primary),
		.secondary              (meas_secondary),
		.lower                  (pt_lower[active_point]),
		.upper                  (pt_upper[active_point]),
		.verdict                (verdict)
	);

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			state        <= S_IDLE;
			active_point <= 4'h_0;
			step_ptr     <= 4'h_0;
			whole_run    <= 1'b0;
			meas_start   <= 1'b0;
			meas_value   <= 32'h_0000_0000;
			result       <= 20'h_0_0000;
		end
		else
		begin
			meas_start <= 1'b0;
			case (state)
			S_IDLE:
			begin
				if (any_trig && trig_target != lss_pkg::NO_POINT)
				begin
					active_point <= trig_target;
					whole_run    <= ctrl[lss_pkg::CTRL_WHOLE];
					if (ctrl[lss_pkg::CTRL_WHOLE])
						result <= 20'h_0_0000;
					state <= S_START;
				end
			end
			S_START:
			begin
				meas_start <= 1'b1;
				meas_value <= pt_value[active_point];
				state      <= S_WAIT;
			end
			S_WAIT:
			begin
				if (meas_done)
				begin
					result[2 * active_point +: 2] <= verdict;
					step_ptr <= active_point + 4'h_1;
					if (whole_run && seq_next != lss_pkg::NO_POINT)
					begin
						active_point <= seq_next;
						state        <= S_START;
					end
					else
						state <= S_IDLE;
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end

	assign sweep_busy = (state != S_IDLE);

	// ****************************************************
	// interrupt status
	// ****************************************************
	always_comb
	begin
		events = 3'h_0;
		if (state == S_WAIT && meas_done)
		begin
			events[lss_pkg::ST_POINT_DONE] = 1'b1;
			events[lss_pkg::ST_POINT_FAIL] = (verdict == lss_pkg::VERDICT_FAIL);
			events[lss_pkg::ST_LIST_DONE]  = ~whole_run |
				(seq_next == lss_pkg::NO_POINT);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			status <= 3'h_0;
			mask   <= 3'h_0;
		end
		else
		begin
			// only bits that were read are cleared; a new event wins
			if (access_rd && paddr == lss_pkg::OFS_STATUS)
				status <= (status & ~prdata[2:0]) | events;
			else
				status <= status | events;
			if (access_wr && paddr == lss_pkg::OFS_MASK)
				mask <= pwdata[2:0];
		end
	end

	assign irq = |(status & mask);
endmodule // lss_list_sweep_sequencer
`default_nettype wire

/* File: tb/lss_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module lss_monitor
(
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        meas_start,
	input wire logic [31:0] meas_value,
	input wire logic [3:0]  active_point,
	input wire logic        sweep_busy,
	input wire logic        irq
);
	// ****
	// port checks
	// ****
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	AST_PREADY_ZERO_WAIT:
	assert property (psel && penable |-> pready)
		else $error("access not answered");
	AST_ERR_ONLY_ACCESS:
	assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	AST_ERR_MISALIGNED:
	assert property (psel && penable && paddr[1:0] != 2'h_0 |-> pslverr)
		else $error("misaligned access accepted");
	AST_START_ONE_CYCLE:
	assert property (meas_start |=> !meas_start [*2])
		else $error("start pulse too long");
	AST_START_IN_RANGE:
	assert property (meas_start |->
		sweep_busy && active_point < 4'(lss_pkg::NUM_POINTS))
		else $error("start outside a sweep");
	AST_START_FOLLOWS_BUSY:
	assert property ($rose(sweep_busy) |=> meas_start)
		else $error("no start after busy");
	AST_POINT_HELD:
	assert property (meas_start |=>
		$stable(active_point) && $stable(meas_value))
		else $error("point moved during measure");
	AST_BUSY_BEFORE_START:
	assert property (meas_start |-> $past(sweep_busy))
		else $error("start without busy lead");
	cover property ($fell(sweep_busy));
	cover property (irq);
	cover property (pslverr);
endmodule // lss_monitor
bind lss_list_sweep_sequencer lss_monitor i_lss_monitor (.sys_clk, .nrst,
	.psel, .penable, .paddr, .pready, .pslverr, .meas_start, .meas_value,
	.active_point, .sweep_busy, .irq);
`default_nettype wire

/* File: tb/lss_engine_model.sv */
`timescale 1ns/10ps
`default_nettype none
module lss_engine_model
(
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        meas_start,
	input  wire logic [31:0] meas_value,
	input  wire logic [3:0]  lag,
	output logic             meas_done,
	output logic      [31:0] meas_primary,
	output logic      [31:0] meas_secondary
);
	// ****
	// measuring engine
	// ****
	int          cnt;
	logic [31:0] held;
	always_ff @(posedge sys_clk)
	begin
		meas_done <= 1'h_0;
		if (!nrst)
			cnt <= 0;
		else if (meas_start)
		begin
			cnt <= int'(lag);
			held <= meas_value;
		end
		else if (cnt == 1)
		begin
			cnt <= 0;
			meas_done <= 1'h_1;
		end
		else if (cnt > 1)
			cnt <= cnt - 1;
	end
	// results valid only with done, scrambled otherwise
	assign meas_primary   = meas_done ? held : ~held;
	assign meas_secondary = meas_done ? ~held : held;
endmodule // lss_engine_model
`default_nettype wire

/* File: tb/lss_list_sweep_sequencer_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module lss_list_sweep_sequencer_bench;
	// ****
	// signals and model
	// ****
	logic        sys_clk, nrst, psel, penable, pwrite, err, free;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, meas_value, meas_primary, meas_secondary;
	logic        pready, pslverr, meas_start, meas_done, sweep_busy, irq;
	logic [2:0]  trg;
	logic [1:0]  sweep_param;
	logic [3:0]  active_point;
	logic [3:0]  lag = 4'h_1;
	logic [11:0] pa;
	logic [31:0] seed, rd, c, val [10], lo [10], hi [10];
	logic [1:0]  sel [10];
	int          n_mismatch, n_tests, cyc;
	int          q [$];
	lss_list_sweep_sequencer i_lss_list_sweep_sequencer (.sys_clk, .nrst,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .key_trig(trg[0]), .handler_trig(trg[1]),
		.bus_trig_cmd(trg[2]), .meas_start, .meas_value, .sweep_param,
		.meas_done, .meas_primary, .meas_secondary, .active_point,
		.sweep_busy, .irq);
	lss_engine_model i_lss_engine_model (.sys_clk, .nrst, .meas_start,
		.meas_value, .lag, .meas_done, .meas_primary, .meas_secondary);
	initial
	begin
		sys_clk = 1'h_0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [1:0] verdict(input int i);
		logic [31:0] v;
		v = (sel[i] == 2'h_2) ? ~val[i] : val[i];
		if (sel[i] == 2'h_0 || sel[i] == 2'h_3)
			return 2'h_0;
		return (v >= lo[i] && v <= hi[i]) ? 2'h_1 : 2'h_2;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'h_1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h_1;
		do @(posedge sys_clk); while (pready !== 1'h_1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h_0;
		penable <= 1'h_0;
	endtask
	task automatic ctl(input int v);
		apb(1'h_1, lss_pkg::OFS_CTRL, 32'(v));
	endtask
	task automatic pulse(input int b);
		@(posedge sys_clk);
		trg[b] <= 1'h_1;
		repeat (2) @(posedge sys_clk);
		trg[b] <= 1'h_0;
	endtask
	task automatic push_all(input int n);
		repeat (n) for (int i = 0; i < 10; i++) if (i != 3) q.push_back(i);
	endtask
	task automatic settle;
		do @(posedge sys_clk); while (q.size() != 0 || sweep_busy !== 1'h_0);
	endtask
	task automatic chk_result;
		logic [31:0] e;
		e = 32'h_0;
		for (int i = 0; i < 10; i++) if (i != 3) e[2*i +: 2] = verdict(i);
		apb(1'h_0, lss_pkg::OFS_RESULT, 32'h_0);
		chk(rd, e);
	endtask
	// ****
	// point watcher and timeout
	// ****
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_mismatch++;
			end_of_test;
		end
		if (nrst === 1'h_1 && meas_start === 1'h_1)
		begin
			seed = lfsr(seed);
			lag <= 4'(seed[2:0]) + 4'h_1;
			if (q.size() > 0)
			begin
				chk(32'(active_point), 32'(q[0]));
				chk(meas_value, val[q[0]]);
				void'(q.pop_front());
			end
			else if (!free)
				chk(32'h_1, 32'h_0);
		end
	end
	// ****
	// main sequence
	// ****
	initial
	begin
		{nrst, psel, penable, pwrite, paddr, pwdata, trg, free} = '0;
		seed = 32'h_0000_d095;
		repeat (5) @(posedge sys_clk);
		nrst <= 1'h_1;
		apb(1'h_0, lss_pkg::OFS_CTRL, 32'h_0);
		chk(rd, lss_pkg::CTRL_RESET);
		apb(1'h_0, 12'h_0f2, 32'h_0);
		chk(32'(err), 32'h_1);
		for (int i = 0; i < 10; i++)
		begin
			seed = lfsr(seed);
			val[i] = seed;
			sel[i] = 2'(i % 4);
			c = (sel[i] == 2'h_2) ? ~seed : seed;
			lo[i] = c;
			hi[i] = (i & 2) ? c : c - 32'h_1;
			pa = lss_pkg::OFS_TABLE + 12'(16 * i);
			apb(1'h_1, pa, val[i]);
			apb(1'h_1, pa + 12'h_4, {29'h_0, sel[i], 1'(i != 3)});
			apb(1'h_1, pa + 12'h_8, lo[i]);
			apb(1'h_1, pa + 12'h_c, hi[i]);
			apb(1'h_0, pa + 12'h_8, 32'h_0);
			chk(rd, lo[i]);
			apb(1'h_0, pa + 12'h_c, 32'h_0);
			chk(rd, hi[i]);
		end
		$display("test table done");
		apb(1'h_1, lss_pkg::OFS_MASK, 32'h_0);
		push_all(1);
		ctl(3);
		settle;
		apb(1'h_0, lss_pkg::OFS_CTRL, 32'h_0);
		chk(rd, 32'h_7);
		chk_result;
		chk(32'(irq), 32'h_0);
		apb(1'h_1, lss_pkg::OFS_MASK, 32'h_2);
		@(posedge sys_clk);
		chk(32'(irq), 32'h_1);
		apb(1'h_0, lss_pkg::OFS_STATUS, 32'h_0);
		chk(rd, 32'h_7);
		@(posedge sys_clk);
		chk(32'(irq), 32'h_0);
		push_all(1);
		pulse(0);
		pulse(0);
		settle;
		chk_result;
		$display("test whole list done");
		q.push_back(0);
		ctl(4);
		ctl(5);
		settle;
		for (int k = 1; k < 10; k++)
		begin
			q.push_back(k < 3 ? k : (k == 9 ? 0 : k + 1));
			pulse(0);
			settle;
		end
		$display("test step done");
		for (int s = 2; s < 4; s++)
		begin
			ctl(3 | s << 2 | (s - 1) << 4);
			@(posedge sys_clk);
			chk(32'(sweep_param), 32'(s - 1));
			pulse(0);
			repeat (4) @(posedge sys_clk);
			chk(32'(sweep_busy), 32'h_0);
			push_all(1);
			pulse(s - 1);
			settle;
			chk_result;
		end
		push_all(1);
		ctl(3 | 3 << 2 | 2 << 4 | 256);
		settle;
		chk_result;
		$display("test sources done");
		free = 1'h_1;
		push_all(2);
		ctl(3);
		do @(posedge sys_clk); while (q.size() != 0);
		ctl(7);
		settle;
		free = 1'h_0;
		$display("test internal done");
		end_of_test;
	end
endmodule // lss_list_sweep_sequencer_bench
`default_nettype wire
